// >>> hw/rtid_pkg.sv
// Constants for the register transfer instruction decoder
package rtid_pkg;
  localparam int          WORD_W       = 10;
  localparam int          DATA_W       = 4;
  localparam int          HIGH_PTR_W   = 2;
  localparam int          THREE_W      = 3;
  // Opcodes
  localparam logic [9:0]  OP_LOAD_ACC_FROM_LOW_PTR      = 10'h01F;
  localparam logic [9:0]  OP_LOAD_ACC_FROM_HIGH_PTR     = 10'h053;
  localparam logic [9:0]  OP_STORE_ACC_TO_AUX           = 10'h00E;
  localparam logic [9:0]  OP_STORE_ACC_TO_THREE_BIT_REG = 10'h029;
  // Reset values and cycles per instruction
  localparam logic [3:0]  ACC_RST      = 4'h0;
  localparam logic [3:0]  AUX_RST      = 4'h0;
  localparam logic [2:0]  THREE_RST    = 3'h0;
  localparam logic [1:0]  CYCLES_PER_INSTR = 2'h1;

  typedef enum logic [2:0] {
    RTID_OP_NONE  = 3'b000,
    RTID_OP_LOW   = 3'b001,
    RTID_OP_HIGH  = 3'b010,
    RTID_OP_AUX   = 3'b011,
    RTID_OP_THREE = 3'b100
  } rtid_op_t;
endpackage

// >>> hw/rtid_decode.sv
// Opcode classifier for the four transfer instructions
`timescale 1ns/1ps
module rtid_decode (
  // Instruction word
  input  wire logic [9:0]        instr,
  // Decoded operation
  output rtid_pkg::rtid_op_t     op
);
  always_comb
  begin
    case (instr)
      rtid_pkg::OP_LOAD_ACC_FROM_LOW_PTR:      op = rtid_pkg::RTID_OP_LOW;
      rtid_pkg::OP_LOAD_ACC_FROM_HIGH_PTR:     op = rtid_pkg::RTID_OP_HIGH;
      rtid_pkg::OP_STORE_ACC_TO_AUX:           op = rtid_pkg::RTID_OP_AUX;
      rtid_pkg::OP_STORE_ACC_TO_THREE_BIT_REG: op = rtid_pkg::RTID_OP_THREE;
      default:                                 op = rtid_pkg::RTID_OP_NONE;
    endcase
  end
endmodule

// >>> hw/rtid_core.sv
// Decode and execute of four register transfer instructions
//
// Function
// - The low-pointer load opcode copies all four low pointer bits into the accumulator.
// - The high-pointer load opcode puts the two high pointer bits into accumulator bits 1:0.
// - That high-pointer load clears accumulator bits 3:2.
// - The aux store opcode copies the accumulator into the aux register, accumulator kept unless acc_wr writes it in the same cycle.
// - The three-bit store opcode copies accumulator bits 2:0, ignoring bit 3.
`timescale 1ns/1ps
module rtid_core #(
  parameter int WORD_W     = rtid_pkg::WORD_W,
  parameter int DATA_W     = rtid_pkg::DATA_W,
  parameter int HIGH_PTR_W = rtid_pkg::HIGH_PTR_W,
  parameter int THREE_W    = rtid_pkg::THREE_W
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // Instruction issue
  input  wire logic [WORD_W-1:0]     instr,
  input  wire logic                  instr_valid,
  // Accumulator load from the rest of the core
  input  wire logic                  acc_wr,
  input  wire logic [DATA_W-1:0]     acc_wdata,
  // Pointer registers
  input  wire logic [DATA_W-1:0]     low_ptr,
  input  wire logic [HIGH_PTR_W-1:0] high_ptr,
  // Carry flag passes through untouched
  input  wire logic                  carry_in,
  // Architectural state
  output logic      [DATA_W-1:0]     acc,
  output logic      [DATA_W-1:0]     aux,
  output logic      [THREE_W-1:0]    three_bit_register,
  output logic                       carry_out,
  // Status
  output logic                       instr_hit,
  output logic                       skip_next
);
  rtid_pkg::rtid_op_t op;
  logic               active;
  logic [DATA_W-1:0]  acc_r;
  logic [DATA_W-1:0]  acc_nxt;
  logic [DATA_W-1:0]  aux_r;
  logic [THREE_W-1:0] three_r;

  // Opcodes and accumulator reset value are fixed ten- and four-bit constants
  if (WORD_W != rtid_pkg::WORD_W || DATA_W != rtid_pkg::DATA_W ||
      HIGH_PTR_W < 1 || HIGH_PTR_W >= DATA_W || THREE_W < 1 || THREE_W > DATA_W)
  begin
    $error("rtid_core: unsupported width parameters");
  end

  // One place for the decode questions asked by the datapath
  function automatic logic executes(input logic valid, input rtid_pkg::rtid_op_t code,
                                    input rtid_pkg::rtid_op_t want);
    return valid && (code == want);
  endfunction

  function automatic logic loads_acc(input logic valid, input rtid_pkg::rtid_op_t code);
    return executes(valid, code, rtid_pkg::RTID_OP_LOW) ||
           executes(valid, code, rtid_pkg::RTID_OP_HIGH);
  endfunction

  function automatic logic [DATA_W-1:0] zero_ext_high(input logic [HIGH_PTR_W-1:0] ptr);
    return {{(DATA_W - HIGH_PTR_W){1'b0}}, ptr};
  endfunction

  rtid_decode u_dec (
    .instr (instr),
    .op    (op)
  );

  assign active = instr_valid && (op != rtid_pkg::RTID_OP_NONE);
  // Handshake-like status, combinational on purpose
  assign instr_hit = active;
  assign skip_next = 1'b0;
  assign carry_out = carry_in;

  always_comb
  begin
    acc_nxt = acc_r;
    if (instr_valid)
    begin
      case (op)
        rtid_pkg::RTID_OP_LOW:  acc_nxt = low_ptr;
        rtid_pkg::RTID_OP_HIGH: acc_nxt = zero_ext_high(high_ptr);
        default:                acc_nxt = acc_r;
      endcase
    end
    // A transfer into the accumulator outranks an external write in the same cycle
    if (acc_wr && !loads_acc(instr_valid, op))
      acc_nxt = acc_wdata;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      acc_r <= rtid_pkg::ACC_RST;
    else
      acc_r <= acc_nxt;
  end

  // Stores read acc_r, so a same-edge external write never leaks into them
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      aux_r <= rtid_pkg::AUX_RST;
    else if (executes(instr_valid, op, rtid_pkg::RTID_OP_AUX))
      aux_r <= acc_r;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      three_r <= THREE_W'(rtid_pkg::THREE_RST);
    else if (executes(instr_valid, op, rtid_pkg::RTID_OP_THREE))
      three_r <= acc_r[THREE_W-1:0];
  end

  assign acc                = acc_r;
  assign aux                = aux_r;
  assign three_bit_register = three_r;

  property p_low;
    @(posedge ref_clk) disable iff (sys_rst)
    (instr_valid && instr == rtid_pkg::OP_LOAD_ACC_FROM_LOW_PTR) |=> acc == $past(low_ptr);
  endproperty
  a_low: assert property (p_low) else $error("low pointer load wrong");

  property p_high;
    @(posedge ref_clk) disable iff (sys_rst)
    (instr_valid && instr == rtid_pkg::OP_LOAD_ACC_FROM_HIGH_PTR)
      |=> acc[HIGH_PTR_W-1:0] == $past(high_ptr);
  endproperty
  a_high: assert property (p_high) else $error("high pointer load wrong");

  property p_high_zero;
    @(posedge ref_clk) disable iff (sys_rst)
    (instr_valid && instr == rtid_pkg::OP_LOAD_ACC_FROM_HIGH_PTR) |=> acc[DATA_W-1:HIGH_PTR_W] == '0;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("upper bits not cleared");

  property p_aux;
    @(posedge ref_clk) disable iff (sys_rst)
    (instr_valid && instr == rtid_pkg::OP_STORE_ACC_TO_AUX && !acc_wr)
      |=> aux == $past(acc) && acc == $past(acc);
  endproperty
  a_aux: assert property (p_aux) else $error("aux store wrong");

  property p_three;
    @(posedge ref_clk) disable iff (sys_rst)
    (instr_valid && instr == rtid_pkg::OP_STORE_ACC_TO_THREE_BIT_REG)
      |=> three_bit_register == $past(acc[THREE_W-1:0]);
  endproperty
  a_three: assert property (p_three) else $error("three-bit store wrong");

  property p_aux_hold;
    @(posedge ref_clk) disable iff (sys_rst)
    !(instr_valid && instr == rtid_pkg::OP_STORE_ACC_TO_AUX) |=> $stable(aux);
  endproperty
  a_aux_hold: assert property (p_aux_hold) else $error("aux changed unexpectedly");

  property p_nskip;
    @(posedge ref_clk) disable iff (sys_rst)
    instr_hit |-> !skip_next && carry_out == carry_in;
  endproperty
  a_nskip: assert property (p_nskip) else $error("skip or carry disturbed");

  property p_three_hold;
    @(posedge ref_clk) disable iff (sys_rst)
    !(instr_valid && instr == rtid_pkg::OP_STORE_ACC_TO_THREE_BIT_REG)
      |=> $stable(three_bit_register);
  endproperty
  a_three_hold: assert property (p_three_hold) else $error("three-bit changed");

  // Decoder-independent view of which words count as one of the four transfers
  property p_hit_map;
    @(posedge ref_clk) disable iff (sys_rst)
    instr_hit == (instr_valid && (instr == rtid_pkg::OP_LOAD_ACC_FROM_LOW_PTR ||
                                  instr == rtid_pkg::OP_LOAD_ACC_FROM_HIGH_PTR ||
                                  instr == rtid_pkg::OP_STORE_ACC_TO_AUX ||
                                  instr == rtid_pkg::OP_STORE_ACC_TO_THREE_BIT_REG));
  endproperty
  a_hit_map: assert property (p_hit_map) else $error("instruction hit wrong");

  property p_acc_hold;
    @(posedge ref_clk) disable iff (sys_rst)
    !acc_wr && !(instr_valid && (instr == rtid_pkg::OP_LOAD_ACC_FROM_LOW_PTR ||
                                 instr == rtid_pkg::OP_LOAD_ACC_FROM_HIGH_PTR))
      |=> $stable(acc);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("accumulator changed");

  property p_store_keeps_acc;
    @(posedge ref_clk) disable iff (sys_rst)
    (instr_valid && !acc_wr && (instr == rtid_pkg::OP_STORE_ACC_TO_AUX ||
                                instr == rtid_pkg::OP_STORE_ACC_TO_THREE_BIT_REG))
      |=> acc == $past(acc);
  endproperty
  a_store_keeps_acc: assert property (p_store_keeps_acc)
    else $error("store disturbed accumulator");

  property p_ext_wr;
    @(posedge ref_clk) disable iff (sys_rst)
    acc_wr && !(instr_valid && (instr == rtid_pkg::OP_LOAD_ACC_FROM_LOW_PTR ||
                                instr == rtid_pkg::OP_LOAD_ACC_FROM_HIGH_PTR))
      |=> acc == $past(acc_wdata);
  endproperty
  a_ext_wr: assert property (p_ext_wr) else $error("external write lost");

  property p_no_skip;
    @(posedge ref_clk) disable iff (sys_rst)
    !skip_next;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("skip raised");

  property p_carry;
    @(posedge ref_clk) disable iff (sys_rst)
    carry_out == carry_in;
  endproperty
  a_carry: assert property (p_carry) else $error("carry altered");

  c_low:   cover property (@(posedge ref_clk) instr_valid && op == rtid_pkg::RTID_OP_LOW);
  c_high:  cover property (@(posedge ref_clk) instr_valid && op == rtid_pkg::RTID_OP_HIGH);
  c_aux:   cover property (@(posedge ref_clk) instr_valid && op == rtid_pkg::RTID_OP_AUX);
  c_three: cover property (@(posedge ref_clk) instr_valid && op == rtid_pkg::RTID_OP_THREE);
  c_clash: cover property (@(posedge ref_clk) instr_hit && acc_wr);
endmodule

// >>> dv/rtid_tb.sv
// Self-checking testbench for the register transfer instruction decoder
`timescale 1ns/1ps
module testbench;
  logic       ref_clk;
  logic       sys_rst;
  logic [9:0] instr;
  logic       instr_valid;
  logic       acc_wr;
  logic [3:0] acc_wdata;
  logic [3:0] low_ptr;
  logic [1:0] high_ptr;
  logic       carry_in;
  logic [3:0] acc;
  logic [3:0] aux;
  logic [2:0] three_bit_register;
  logic       carry_out;
  logic       instr_hit;
  logic       skip_next;
  int         fail_count;
  int         n_tests;
  int         cycles;

  rtid_core DUT (.ref_clk, .sys_rst, .instr, .instr_valid, .acc_wr, .acc_wdata, .low_ptr,
    .high_ptr, .carry_in, .acc, .aux, .three_bit_register, .carry_out, .instr_hit, .skip_next);

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // The scenarios take a few dozen cycles, so this ceiling only cuts a hang
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Presents one word for one cycle; the carry toggles so pass-through is really exercised
  task automatic issue(input logic [9:0] op, input logic wr, input logic [3:0] wd,
                       input logic exp_hit);
    @(negedge ref_clk);
    instr = op;
    instr_valid = 1'b1;
    acc_wr = wr;
    acc_wdata = wd;
    carry_in = ~carry_in;
    #1;
    chk("instr_hit", {3'h0, exp_hit}, {3'h0, instr_hit});
    chk("carry_out", {3'h0, carry_in}, {3'h0, carry_out});
    chk("skip_next", 4'h0, {3'h0, skip_next});
  endtask

  task automatic idle();
    @(negedge ref_clk);
    instr_valid = 1'b0;
    acc_wr = 1'b0;
  endtask

  task automatic t_low();
    low_ptr = 4'h9;
    issue(rtid_pkg::OP_LOAD_ACC_FROM_LOW_PTR, 1'b1, 4'h5, 1'b1);
    idle();
    chk("acc", 4'h9, acc);
  endtask

  task automatic t_high();
    high_ptr = 2'h2;
    issue(10'h3FF, 1'b1, 4'hF, 1'b0);
    issue(rtid_pkg::OP_LOAD_ACC_FROM_HIGH_PTR, 1'b0, 4'h0, 1'b1);
    idle();
    chk("acc", 4'h2, acc);
  endtask

  task automatic t_aux();
    issue(10'h3FF, 1'b1, 4'hA, 1'b0);
    issue(rtid_pkg::OP_STORE_ACC_TO_AUX, 1'b0, 4'h0, 1'b1);
    idle();
    chk("aux", 4'hA, aux);
    chk("acc", 4'hA, acc);
  endtask

  // Back to back: the store must see the value the load just wrote
  task automatic t_three();
    low_ptr = 4'hE;
    issue(rtid_pkg::OP_LOAD_ACC_FROM_LOW_PTR, 1'b0, 4'h0, 1'b1);
    issue(rtid_pkg::OP_STORE_ACC_TO_THREE_BIT_REG, 1'b0, 4'h0, 1'b1);
    idle();
    chk("three_bit_register", 4'h6, {1'b0, three_bit_register});
    chk("aux", 4'hA, aux);
  endtask

  // External writes beside transfers: loads win, stores take the old accumulator
  task automatic t_clash();
    issue(rtid_pkg::OP_STORE_ACC_TO_AUX, 1'b1, 4'hC, 1'b1);
    idle();
    chk("aux", 4'hE, aux);
    chk("acc", 4'hC, acc);
    high_ptr = 2'h1;
    issue(rtid_pkg::OP_LOAD_ACC_FROM_HIGH_PTR, 1'b1, 4'h3, 1'b1);
    idle();
    chk("acc", 4'h1, acc);
    issue(rtid_pkg::OP_STORE_ACC_TO_THREE_BIT_REG, 1'b1, 4'hF, 1'b1);
    idle();
    chk("three_bit_register", 4'h1, {1'b0, three_bit_register});
    chk("acc", 4'hF, acc);
  endtask

  // Reset in mid-run clears every register at once, without waiting for an edge
  task automatic t_reset();
    @(negedge ref_clk);
    sys_rst = 1'b1;
    #1;
    chk("acc", rtid_pkg::ACC_RST, acc);
    chk("aux", rtid_pkg::AUX_RST, aux);
    chk("three_bit_register", {1'b0, rtid_pkg::THREE_RST}, {1'b0, three_bit_register});
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    low_ptr = 4'h7;
    issue(rtid_pkg::OP_LOAD_ACC_FROM_LOW_PTR, 1'b0, 4'h0, 1'b1);
    idle();
    chk("acc", 4'h7, acc);
    chk("aux", rtid_pkg::AUX_RST, aux);
  endtask

  initial
  begin
    {instr, instr_valid, acc_wr, acc_wdata, low_ptr, high_ptr, carry_in} = '0;
    fail_count = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    chk("acc", rtid_pkg::ACC_RST, acc);
    chk("aux", rtid_pkg::AUX_RST, aux);
    chk("three_bit_register", {1'b0, rtid_pkg::THREE_RST}, {1'b0, three_bit_register});
    t_low();
    t_high();
    t_aux();
    t_three();
    t_clash();
    t_reset();
    give_verdict();
  end
endmodule
